// ### rtl/rprom_array.sv
// Fuse array: WORDS x DATA_W cells, read data registered.
// Assumes the owner presents the address before the capturing edge.
module rprom_array #(
   parameter int unsigned WORDS = rprom_pkg::WORDS
) (
   input wire logic core_clk_in,
   input wire logic rst_in,
   rprom_array_if.array bus
);
   logic [rprom_pkg::DATA_W-1:0] cell_ff [WORDS];
   logic [rprom_pkg::DATA_W-1:0] nxt_cell;
   logic [rprom_pkg::DATA_W-1:0] rd_ff;
   logic [rprom_pkg::DATA_W-1:0] nxt_rd;

   // Fuses only ever blow 0 to 1, so OR in the new bits
   always_comb begin
      nxt_cell = cell_ff[bus.prog_addr] | bus.prog_bits;
      nxt_rd = cell_ff[bus.rd_addr];
   end

   // Cells reset blank; the read word is the slave stage
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         for (int i = 0; i < WORDS; i++) begin
            cell_ff[i] <= rprom_pkg::BLANK_WORD;
         end
         rd_ff <= rprom_pkg::BLANK_WORD;
      end else begin
         if (bus.prog_en) begin
            cell_ff[bus.prog_addr] <= nxt_cell;
         end
         rd_ff <= nxt_rd;
      end
   end

   assign bus.rd_data = rd_ff;

   // A blown bit never returns to zero
   property p_fuse_one_way;
      @(posedge core_clk_in) disable iff (rst_in)
         bus.prog_en |=> ((cell_ff[$past(bus.prog_addr)] & $past(nxt_cell)) == $past(nxt_cell));
   endproperty
   a_fuse_one_way: assert property (p_fuse_one_way)
      else $error("programmed bit cleared");
endmodule

// ### rtl/rprom_array_if.sv
// Interface between the read port and its fuse array.
// Assumes both ends share core_clk_in.
interface rprom_array_if #(
   parameter int unsigned ADDR_W = 9,
   parameter int unsigned DATA_W = 8
);
   logic [ADDR_W-1:0] rd_addr;
   logic [DATA_W-1:0] rd_data;
   logic prog_en;
   logic [ADDR_W-1:0] prog_addr;
   logic [DATA_W-1:0] prog_bits;
   modport port (output rd_addr, output prog_en, output prog_addr, output prog_bits,
      input rd_data);
   modport array (input rd_addr, input prog_en, input prog_addr, input prog_bits,
      output rd_data);
endinterface

// ### rtl/rprom_pkg.sv
// Package for the registered read-only memory read port.
// Assumes a single core clock; no software-visible registers.
package rprom_pkg;
   localparam int unsigned WORDS = 512;
   localparam int unsigned ADDR_W = 9;
   localparam int unsigned DATA_W = 8;
   // Unprogrammed cells read as zero
   localparam logic [7:0] BLANK_WORD = 8'h00;
   // Sync enable powers up disabled (active low, so high)
   localparam logic SYNC_EN_RST = 1'b1;
   // Output enable pin level: low drives
   localparam logic OE_DRIVE = 1'b0;
   localparam logic OE_RELEASE = 1'b1;
endpackage

// ### rtl/rprom_top.sv
// Registered 512x8 one-time-programmable read port with
// synchronous and asynchronous output enables.
// Assumes pins are synchronised by two flops before use.
// Functional notes
// - 512 words of 8 bits, 9-bit address
// - Addressed word loads the master stage
// - Rising edge moves word to slave stage
// - Output word held until next edge
// - Sync enable high at edge floats outputs
// - Async enable high always floats outputs
// - Drive only when both enables low
// - Sync enable flop powers up disabled
// - Enables allow shared bus; one active
// - Blank device reads zero everywhere
// - Programming only sets bits, never clears
module rprom_top #(
   parameter int unsigned WORDS = rprom_pkg::WORDS
) (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic [rprom_pkg::ADDR_W-1:0] word_select_in,
   input wire logic sync_out_enable_n_in,
   input wire logic async_out_enable_n_in,
   input wire logic prog_en_in,
   input wire logic [rprom_pkg::ADDR_W-1:0] prog_addr_in,
   input wire logic [rprom_pkg::DATA_W-1:0] prog_bits_in,
   output logic [rprom_pkg::DATA_W-1:0] read_word_out,
   output logic read_word_oe_n_out
);
   localparam int unsigned AW = rprom_pkg::ADDR_W;
   localparam int unsigned DW = rprom_pkg::DATA_W;

   // Pin synchronisers: stage one is read only by stage two
   logic [AW-1:0] addr_s1_ff, addr_s2_ff;
   logic sync_en_s1_ff, sync_en_s2_ff, g_s1_ff, g_s2_ff;
   logic pe_s1_ff, pe_s2_ff;
   logic [AW-1:0] pa_s1_ff, pa_s2_ff;
   logic [DW-1:0] pb_s1_ff, pb_s2_ff;
   logic sync_en_n_ff;
   logic nxt_sync_en_n;
   logic [DW-1:0] word_ff;
   logic [DW-1:0] nxt_word;

   rprom_array_if #(.ADDR_W(AW), .DATA_W(DW)) arr_if ();

   rprom_array #(.WORDS(WORDS)) u_array (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .bus(arr_if.array)
   );

   // Two-flop capture of every pin input
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         addr_s1_ff <= '0;
         addr_s2_ff <= '0;
         sync_en_s1_ff <= rprom_pkg::SYNC_EN_RST;
         sync_en_s2_ff <= rprom_pkg::SYNC_EN_RST;
         g_s1_ff <= rprom_pkg::OE_RELEASE;
         g_s2_ff <= rprom_pkg::OE_RELEASE;
         pe_s1_ff <= 1'b0;
         pe_s2_ff <= 1'b0;
         pa_s1_ff <= '0;
         pa_s2_ff <= '0;
         pb_s1_ff <= '0;
         pb_s2_ff <= '0;
      end else begin
         addr_s1_ff <= word_select_in;
         addr_s2_ff <= addr_s1_ff;
         sync_en_s1_ff <= sync_out_enable_n_in;
         sync_en_s2_ff <= sync_en_s1_ff;
         g_s1_ff <= async_out_enable_n_in;
         g_s2_ff <= g_s1_ff;
         pe_s1_ff <= prog_en_in;
         pe_s2_ff <= pe_s1_ff;
         pa_s1_ff <= prog_addr_in;
         pa_s2_ff <= pa_s1_ff;
         pb_s1_ff <= prog_bits_in;
         pb_s2_ff <= pb_s1_ff;
      end
   end

   // Array access: address feeds the master stage
   assign arr_if.rd_addr = addr_s2_ff;
   assign arr_if.prog_en = pe_s2_ff;
   assign arr_if.prog_addr = pa_s2_ff;
   assign arr_if.prog_bits = pb_s2_ff;

   // Sync enable sampled each edge; output word is the array slave
   always_comb begin
      nxt_sync_en_n = sync_en_s2_ff;
      nxt_word = arr_if.rd_data;
   end

   // Output register and enable flop; reset is the power-up state
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         sync_en_n_ff <= rprom_pkg::SYNC_EN_RST;
         word_ff <= rprom_pkg::BLANK_WORD;
      end else begin
         sync_en_n_ff <= nxt_sync_en_n;
         word_ff <= nxt_word;
      end
   end

   // Drivers on only with both enables low; bus sharing relies on it
   assign read_word_out = word_ff;
   assign read_word_oe_n_out = (sync_en_n_ff == 1'b0 && g_s2_ff == 1'b0)
      ? rprom_pkg::OE_DRIVE : rprom_pkg::OE_RELEASE;

   // Enable checks: drivers follow the two synced enables
   property p_async_float;
      @(posedge core_clk_in) disable iff (rst_in)
         g_s2_ff |-> read_word_oe_n_out == rprom_pkg::OE_RELEASE;
   endproperty
   a_async_float: assert property (p_async_float)
      else $error("async enable high but outputs driven");

   property p_sync_float;
      @(posedge core_clk_in) disable iff (rst_in)
         sync_en_s2_ff |=> read_word_oe_n_out == rprom_pkg::OE_RELEASE;
   endproperty
   a_sync_float: assert property (p_sync_float)
      else $error("sync enable high but outputs driven next cycle");

   property p_drive;
      @(posedge core_clk_in) disable iff (rst_in)
         (!sync_en_s2_ff ##1 !g_s2_ff) |-> read_word_oe_n_out == rprom_pkg::OE_DRIVE;
   endproperty
   a_drive: assert property (p_drive)
      else $error("both enables low but outputs floating");

   // Data path: the cell addressed two edges back is the output word
   property p_word_path;
      @(posedge core_clk_in) disable iff (rst_in)
         ##2 read_word_out == $past(u_array.cell_ff[addr_s2_ff], 2);
   endproperty
   a_word_path: assert property (p_word_path)
      else $error("output word differs from addressed cell");

   property p_retained;
      @(posedge core_clk_in) disable iff (rst_in)
         ($stable(arr_if.rd_data) && g_s2_ff) |=> $stable(read_word_out);
   endproperty
   a_retained: assert property (p_retained)
      else $error("word changed while only async enable moved");

   // Power-up clears every cell, so the addressed word reads blank
   property p_blank;
      @(posedge core_clk_in)
         rst_in |=> (u_array.cell_ff[addr_s2_ff] == rprom_pkg::BLANK_WORD)
            && (read_word_out == rprom_pkg::BLANK_WORD);
   endproperty
   a_blank: assert property (p_blank)
      else $error("blank check");

   property p_reset_off;
      @(posedge core_clk_in) $fell(rst_in) |-> read_word_oe_n_out == rprom_pkg::OE_RELEASE;
   endproperty
   a_reset_off: assert property (p_reset_off)
      else $error("outputs driven right after reset");

   property p_hold;
      @(posedge core_clk_in) disable iff (rst_in)
         1'b1 |=> read_word_out == $past(arr_if.rd_data);
   endproperty
   a_hold: assert property (p_hold)
      else $error("output word not the slave stage of the last edge");

   // A high sync flop keeps the drivers off until an enabled edge
   property p_sync_hold_float;
      @(posedge core_clk_in) disable iff (rst_in)
         sync_en_n_ff |-> read_word_oe_n_out == rprom_pkg::OE_RELEASE;
   endproperty
   a_sync_hold_float: assert property (p_sync_hold_float)
      else $error("sync flop disabled but outputs driven");

   // The sync flop takes the synced pin level at every edge
   property p_sync_sample;
      @(posedge core_clk_in) disable iff (rst_in)
         1'b1 |=> sync_en_n_ff == $past(sync_en_s2_ff);
   endproperty
   a_sync_sample: assert property (p_sync_sample)
      else $error("sync flop missed the enable level");

   // Driving needs both enables low; a shared bus depends on this
   property p_drive_needs_both;
      @(posedge core_clk_in) disable iff (rst_in)
         (read_word_oe_n_out == rprom_pkg::OE_DRIVE) |-> (!sync_en_n_ff && !g_s2_ff);
   endproperty
   a_drive_needs_both: assert property (p_drive_needs_both)
      else $error("outputs driven with an enable high");

   // Held word comes back on the drivers once the async enable drops
   property p_async_return;
      @(posedge core_clk_in) disable iff (rst_in)
         ($fell(g_s2_ff) && !sync_en_n_ff) |-> read_word_oe_n_out == rprom_pkg::OE_DRIVE;
   endproperty
   a_async_return: assert property (p_async_return)
      else $error("drivers stayed off after async enable returned");

   // A strobe sets every requested bit in the addressed word
   property p_burn_sets;
      @(posedge core_clk_in) disable iff (rst_in)
         arr_if.prog_en |=> (u_array.cell_ff[$past(arr_if.prog_addr)] & $past(arr_if.prog_bits))
            == $past(arr_if.prog_bits);
   endproperty
   a_burn_sets: assert property (p_burn_sets)
      else $error("programmed bit not set");

   // Without a strobe the addressed cell keeps its contents
   property p_no_stray_write;
      @(posedge core_clk_in) disable iff (rst_in)
         !arr_if.prog_en |=> u_array.cell_ff[$past(arr_if.rd_addr)]
            == $past(u_array.cell_ff[arr_if.rd_addr]);
   endproperty
   a_no_stray_write: assert property (p_no_stray_write)
      else $error("cell changed without a programming strobe");

   // Address reaches the array from the second sync stage only
   property p_addr_path;
      @(posedge core_clk_in) disable iff (rst_in)
         1'b1 |=> arr_if.rd_addr == $past(addr_s1_ff);
   endproperty
   a_addr_path: assert property (p_addr_path)
      else $error("array address not from the second sync stage");
endmodule

// ### test/registered_prom_read_port_test.sv
// Self-checking bench for the registered read port.
// Assumes the controller model drives every input of the port but clock and reset.
module registered_prom_read_port_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk_in;
   logic rst_in;
   logic [8:0] ws;
   logic sync_n;
   logic g_n;
   logic pen;
   logic [8:0] pa;
   logic [7:0] pb;
   logic [7:0] q;
   logic oe_n;
   int n_mismatch = 0;
   int n_checks = 0;
   int cyc = 0;
   rprom_ctrl_model u_rprom_ctrl_model (.core_clk_in(core_clk_in), .word_select_out(ws),
      .sync_out_enable_n_out(sync_n), .async_out_enable_n_out(g_n), .prog_en_out(pen),
      .prog_addr_out(pa), .prog_bits_out(pb));
   rprom_top u_rprom_top (.core_clk_in(core_clk_in), .rst_in(rst_in), .word_select_in(ws),
      .sync_out_enable_n_in(sync_n), .async_out_enable_n_in(g_n), .prog_en_in(pen),
      .prog_addr_in(pa), .prog_bits_in(pb), .read_word_out(q), .read_word_oe_n_out(oe_n));
   // 40 MHz clock
   initial begin
      core_clk_in = 1'b0;
      forever #12.5 core_clk_in = ~core_clk_in;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Longer than the four-edge read latency, so outputs have settled
   task automatic rd(input logic [8:0] a, input logic s, input logic g);
      u_rprom_ctrl_model.drive(a, s, g);
      repeat (6) @(posedge core_clk_in);
      #1;
   endtask
   task automatic t_blank;
      chk({7'h00, oe_n}, 8'h01);
      rd(9'h000, 1'b0, 1'b0);
      chk(q, 8'h00);
      chk({7'h00, oe_n}, 8'h00);
      rd(9'h1ff, 1'b0, 1'b0);
      chk(q, 8'h00);
   endtask
   task automatic t_prog;
      u_rprom_ctrl_model.burn(9'h005, 8'h5a);
      u_rprom_ctrl_model.burn(9'h005, 8'h0f);
      u_rprom_ctrl_model.burn(9'h005, 8'h00);
      rd(9'h005, 1'b0, 1'b0);
      chk(q, 8'h5f);
      u_rprom_ctrl_model.drive(9'h004, 1'b0, 1'b0);
      @(posedge core_clk_in);
      #1;
      chk(q, 8'h5f);
      repeat (5) @(posedge core_clk_in);
      #1;
      chk(q, 8'h00);
   endtask
   task automatic t_enables;
      rd(9'h005, 1'b1, 1'b0);
      chk({7'h00, oe_n}, 8'h01);
      rd(9'h005, 1'b0, 1'b1);
      chk({7'h00, oe_n}, 8'h01);
      chk(q, 8'h5f);
      rd(9'h005, 1'b0, 1'b0);
      chk({7'h00, oe_n}, 8'h00);
      chk(q, 8'h5f);
   endtask
   task automatic results;
      $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Hang guard, well above the roughly 60 cycles the scenarios take
   always @(posedge core_clk_in) begin
      cyc++;
      if (cyc == 2000) begin
         n_mismatch++;
         results();
      end
   end
   initial begin
      rst_in = 1'b1;
      repeat (4) @(posedge core_clk_in);
      rst_in <= 1'b0;
      @(posedge core_clk_in);
      #1;
      t_blank();
      t_prog();
      t_enables();
      results();
   end
endmodule

// ### test/rprom_ctrl_model.sv
// Controller model: drives read address, enables and programming port.
// Assumes bench calls its tasks; pins change only just after a rising edge.
module rprom_ctrl_model (
   input wire logic core_clk_in,
   output logic [rprom_pkg::ADDR_W-1:0] word_select_out,
   output logic sync_out_enable_n_out,
   output logic async_out_enable_n_out,
   output logic prog_en_out,
   output logic [rprom_pkg::ADDR_W-1:0] prog_addr_out,
   output logic [rprom_pkg::DATA_W-1:0] prog_bits_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // Power-up: nothing enabled, nothing burnt
   initial begin
      word_select_out = 9'h000;
      sync_out_enable_n_out = 1'b1;
      async_out_enable_n_out = 1'b1;
      prog_en_out = 1'b0;
      prog_addr_out = 9'h000;
      prog_bits_out = 8'h00;
   end
   // Address and enables held until the next request
   // Only this one device is ever enabled on the bus
   task automatic drive(input logic [8:0] a, input logic sync_n, input logic g_n);
      @(posedge core_clk_in);
      word_select_out <= a;
      sync_out_enable_n_out <= sync_n;
      async_out_enable_n_out <= g_n;
   endtask
   // One-cycle burn strobe; bits inverted after release so stale data never counts
   task automatic burn(input logic [8:0] a, input logic [7:0] b);
      @(posedge core_clk_in);
      prog_en_out <= 1'b1;
      prog_addr_out <= a;
      prog_bits_out <= b;
      @(posedge core_clk_in);
      prog_en_out <= 1'b0;
      prog_bits_out <= ~b;
   endtask
endmodule
